// File: rtl/csmon_pkg.sv
/*
  Constants and types for the channel-status and error-flag monitor.
  Assumes a 25 MHz pclk and a receiver front end that delivers decoded
  subframes as strobes on the same clock.
*/
package csmon_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SHORT_PERSIST_MS = 1000;
  localparam int LONG_PERSIST_MS = 5000;
  localparam int SHORT_PERSIST_CYC = (CLK_HZ / 1000) * SHORT_PERSIST_MS;
  localparam int LONG_PERSIST_CYC = (CLK_HZ / 1000) * LONG_PERSIST_MS;
  localparam int BLOCK_FRAMES = 192;
  localparam int MIN_MEAS_SAMPLES = 2 * BLOCK_FRAMES;
  localparam int CS_BITS = 40;
  localparam int SAMPLE_CNT_W = 10;
  localparam int BIT_IDX_W = 8;
  localparam int PERSIST_W = 28;
  localparam int BIT_FORMAT = 0;
  localparam int BIT_AUDIO_MODE = 1;

  // APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_CH1_LO = 8'h08;
  localparam logic [7:0] REG_CH1_HI = 8'h0C;
  localparam logic [7:0] REG_CH2_LO = 8'h10;
  localparam logic [7:0] REG_CH2_HI = 8'h14;
  localparam logic [7:0] REG_MARK1_LO = 8'h18;
  localparam logic [7:0] REG_MARK1_HI = 8'h1C;
  localparam logic [7:0] REG_MARK2_LO = 8'h20;
  localparam logic [7:0] REG_MARK2_HI = 8'h24;
  localparam logic [7:0] REG_REF_LO = 8'h28;
  localparam logic [7:0] REG_REF_HI = 8'h2C;

  // CTRL field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_VIDEO_SRC = 2;
  localparam int CTRL_LAYOUT_LSB = 4;
  localparam int CTRL_MARK_LSB = 6;
  localparam int CTRL_PERSIST_LSB = 8;
  localparam int CTRL_START = 31;

  // FLAGS field positions
  localparam int FLG_LOCK = 0;
  localparam int FLG_PARITY = 1;
  localparam int FLG_CRC = 2;
  localparam int FLG_NONPCM = 3;
  localparam int FLG_CHANNEL1_VALIDITY_FLAG = 4;
  localparam int FLG_CHANNEL2_VALIDITY_FLAG = 5;
  localparam int FLG_PRO1 = 6;
  localparam int FLG_PRO2 = 7;
  localparam int FLG_BUSY = 8;

  typedef enum logic [1:0] {LAYOUT_AUTO, LAYOUT_CONSUMER, LAYOUT_PRO} csmon_layout_e;
  typedef enum logic [1:0] {MARK_NONE, MARK_GEN, MARK_CHAN, MARK_CHANGES} csmon_mark_e;
  typedef enum logic [1:0] {PERSIST_SHORT, PERSIST_LONG, PERSIST_FOREVER} csmon_persist_e;
endpackage

// File: rtl/csmon_monitor.sv
/*
  Channel-status gather/decode, change marking and error flags, with an
  APB slave for control and readback.
  Assumes the receiver front end delivers one strobe per subframe on pclk
  with its status, validity and parity-fail bits, a block-start marker and
  a lock level that arrives from outside and is synchronised here.
*/
// Summary of operation
// - Status of channel 1 then channel 2 is gathered in turn, two blocks.
// - A measurement cycle lasts at least 384 samples and until both are complete.
// - With decoding disabled the decoded status is held unchanged.
// - Status bit 0 low means consumer layout, high means professional.
// - Automatic mode picks each channel's layout from its own format bit.
// - Forced modes use the chosen layout and ignore the format bit.
// - Five status bytes per channel are decoded and shown for both channels.
// - The video-link source uses consumer bytes 0 to 4 only.
// - The video-link source reports one status set on both channels.
// - The serial source decodes both channels always.
// - Marking modes: none, differs from generator, differs between channels.
// - Changes mode marks fields changed since the end of the first cycle after a start.
// - Marks expire after one second, five seconds, or never.
// - Starting a measurement clears all marks.
// - Flags are sampled at cycle end and single mode holds them; status updates at each gathered block.
// - A flag returns to no error when the condition is gone at sampling.
// - Non-PCM flag follows status bit 1.
// - Parity flag shows any parity mismatch.
// - Lock flag shows missing valid input.
// - CRC flag reports failures only in professional layout.
// - Each channel's invalid flag follows its validity bit.
// - Loss of lock forces all error flags to error.
module csmon_monitor
  import csmon_pkg::*;
#(
  parameter int SHORT_CYC = SHORT_PERSIST_CYC,
  parameter int LONG_CYC = LONG_PERSIST_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver front end
  input wire logic lock_pin,
  input wire logic sub_stb,
  input wire logic sub_chan,
  input wire logic sub_block_start,
  input wire logic sub_status,
  input wire logic sub_validity,
  input wire logic sub_parity_err,
  input wire logic crc_err_stb,
  // Status produced by the internal generator
  input wire logic [CS_BITS-1:0] gen_status,
  // Flag outputs
  output logic channel1_validity_flag,
  output logic channel2_validity_flag,
  output logic meas_done
);
  typedef struct packed {
    logic [1:0] lock_sync;
    logic enable;
    logic single;
    logic video_src;
    csmon_layout_e layout;
    csmon_mark_e mark_mode;
    csmon_persist_e persist;
    logic busy;
    logic [SAMPLE_CNT_W-1:0] samples;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic gather_chan;
    logic gathering;
    logic [1:0] done_ch;
    logic [CS_BITS-1:0] shift;
    logic [CS_BITS-1:0] cs1;
    logic [CS_BITS-1:0] cs2;
    logic [CS_BITS-1:0] ref1;
    logic [CS_BITS-1:0] ref2;
    logic ref_valid;
    logic [CS_BITS-1:0] mark1;
    logic [CS_BITS-1:0] mark2;
    logic [PERSIST_W-1:0] age;
    logic acc_parity;
    logic acc_crc;
    logic acc_inv1;
    logic acc_inv2;
    logic acc_unlock;
    logic [8:0] flags;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic inv1;
    logic inv2;
    logic done;
  } csmon_state_s;

  csmon_state_s st_ff;
  csmon_state_s nxt_st;

  function automatic logic is_pro(input csmon_layout_e mode, input logic fmt_bit);
    case (mode)
      LAYOUT_CONSUMER: is_pro = 1'b0;
      LAYOUT_PRO: is_pro = 1'b1;
      default: is_pro = fmt_bit;
    endcase
  endfunction

  // Flags read as errors until the first cycle has been sampled
  localparam logic [8:0] RST_FLAGS = 9'h03F;

  // Readback of one 32-bit half of a 40-bit status word
  function automatic logic [31:0] cs_half(input logic [CS_BITS-1:0] word, input logic hi);
    if (hi) begin
      cs_half = {24'h0, word[CS_BITS-1:32]};
    end else begin
      cs_half = word[31:0];
    end
  endfunction

  // CTRL readback: busy shows in the start position
  function automatic logic [31:0] ctrl_word(input csmon_state_s s);
    ctrl_word = '0;
    ctrl_word[CTRL_START] = s.busy;
    ctrl_word[CTRL_PERSIST_LSB +: 2] = 2'(s.persist);
    ctrl_word[CTRL_MARK_LSB +: 2] = 2'(s.mark_mode);
    ctrl_word[CTRL_LAYOUT_LSB +: 2] = 2'(s.layout);
    ctrl_word[CTRL_VIDEO_SRC] = s.video_src;
    ctrl_word[CTRL_SINGLE] = s.single;
    ctrl_word[CTRL_ENABLE] = s.enable;
  endfunction

  // FLAGS readback with the busy bit
  function automatic logic [31:0] flags_word(input csmon_state_s s);
    flags_word = '0;
    flags_word[FLG_BUSY] = s.busy;
    flags_word[FLG_PRO2:FLG_LOCK] = s.flags[FLG_PRO2:FLG_LOCK];
  endfunction

  logic locked;
  logic pro1;
  logic pro2;
  logic [CS_BITS-1:0] diff1;
  logic [CS_BITS-1:0] diff2;
  logic [PERSIST_W-1:0] persist_lim;
  logic apb_acc;

  assign locked = st_ff.lock_sync[1];
  assign pro1 = st_ff.video_src ? 1'b0 : is_pro(st_ff.layout, st_ff.cs1[BIT_FORMAT]);
  // Video-link status is consumer-only
  assign pro2 = st_ff.video_src ? 1'b0 : is_pro(st_ff.layout, st_ff.cs2[BIT_FORMAT]);
  assign apb_acc = psel && penable && !st_ff.pready;
  assign persist_lim = (st_ff.persist == PERSIST_LONG) ? PERSIST_W'(LONG_CYC) : PERSIST_W'(SHORT_CYC);

  always_comb begin
    case (st_ff.mark_mode)
      MARK_GEN: begin
        diff1 = st_ff.cs1 ^ gen_status;
        diff2 = st_ff.cs2 ^ gen_status;
      end
      MARK_CHAN: begin
        diff1 = st_ff.cs1 ^ st_ff.cs2;
        diff2 = st_ff.cs1 ^ st_ff.cs2;
      end
      MARK_CHANGES: begin
        diff1 = st_ff.ref_valid ? (st_ff.cs1 ^ st_ff.ref1) : '0;
        diff2 = st_ff.ref_valid ? (st_ff.cs2 ^ st_ff.ref2) : '0;
      end
      default: begin
        diff1 = '0;
        diff2 = '0;
      end
    endcase
  end

  always_comb begin
    logic start;
    logic sample_end;
    start = 1'b0;
    sample_end = 1'b0;
    nxt_st = st_ff;
    nxt_st.lock_sync = {st_ff.lock_sync[0], lock_pin};
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.done = 1'b0;

    // APB access, answered one cycle after the access phase begins
    if (apb_acc) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = '0;
      if (pwrite) begin
        if (paddr == REG_CTRL) begin
          nxt_st.enable = pwdata[CTRL_ENABLE];
          nxt_st.single = pwdata[CTRL_SINGLE];
          nxt_st.video_src = pwdata[CTRL_VIDEO_SRC];
          nxt_st.layout = csmon_layout_e'(pwdata[CTRL_LAYOUT_LSB +: 2]);
          nxt_st.mark_mode = csmon_mark_e'(pwdata[CTRL_MARK_LSB +: 2]);
          nxt_st.persist = csmon_persist_e'(pwdata[CTRL_PERSIST_LSB +: 2]);
          start = pwdata[CTRL_START];
        end else begin
          nxt_st.pslverr = 1'b1;
        end
      end else begin
        case (paddr)
          REG_CTRL: begin
            nxt_st.prdata = ctrl_word(st_ff);
          end
          REG_FLAGS: begin
            nxt_st.prdata = flags_word(st_ff);
          end
          REG_CH1_LO: begin
            nxt_st.prdata = cs_half(st_ff.cs1, 1'b0);
          end
          REG_CH1_HI: begin
            nxt_st.prdata = cs_half(st_ff.cs1, 1'b1);
          end
          REG_CH2_LO: begin
            nxt_st.prdata = cs_half(st_ff.cs2, 1'b0);
          end
          REG_CH2_HI: begin
            nxt_st.prdata = cs_half(st_ff.cs2, 1'b1);
          end
          REG_MARK1_LO: begin
            nxt_st.prdata = cs_half(st_ff.mark1, 1'b0);
          end
          REG_MARK1_HI: begin
            nxt_st.prdata = cs_half(st_ff.mark1, 1'b1);
          end
          REG_MARK2_LO: begin
            nxt_st.prdata = cs_half(st_ff.mark2, 1'b0);
          end
          REG_MARK2_HI: begin
            nxt_st.prdata = cs_half(st_ff.mark2, 1'b1);
          end
          REG_REF_LO: begin
            nxt_st.prdata = cs_half(st_ff.ref1, 1'b0);
          end
          REG_REF_HI: begin
            nxt_st.prdata = cs_half(st_ff.ref1, 1'b1);
          end
          default: begin
            nxt_st.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Measurement start, or automatic restart in continuous mode
    if (start || (!st_ff.single && !st_ff.busy && st_ff.enable)) begin
      nxt_st.busy = 1'b1;
      nxt_st.samples = '0;
      // The enable written with the start decides whether status must be gathered
      nxt_st.done_ch = nxt_st.enable ? 2'b00 : 2'b11;
      // A block begun before the start may carry stale status: wait for a fresh one
      nxt_st.gathering = 1'b0;
      nxt_st.acc_parity = 1'b0;
      nxt_st.acc_crc = 1'b0;
      nxt_st.acc_inv1 = 1'b0;
      nxt_st.acc_inv2 = 1'b0;
      nxt_st.acc_unlock = !locked;
    end
    if (start) begin
      nxt_st.mark1 = '0;
      nxt_st.mark2 = '0;
      nxt_st.age = '0;
      nxt_st.ref_valid = 1'b0;
    end

    if (st_ff.busy && !start) begin
      if (!locked) begin
        nxt_st.acc_unlock = 1'b1;
      end
      if (crc_err_stb) begin
        nxt_st.acc_crc = 1'b1;
      end
      if (sub_stb) begin
        if (sub_parity_err) begin
          nxt_st.acc_parity = 1'b1;
        end
        if (sub_validity && !sub_chan) begin
          nxt_st.acc_inv1 = 1'b1;
        end
        if (sub_validity && sub_chan) begin
          nxt_st.acc_inv2 = 1'b1;
        end
        if (!sub_chan && st_ff.samples != SAMPLE_CNT_W'(MIN_MEAS_SAMPLES)) begin
          nxt_st.samples = st_ff.samples + 1'b1;
        end
      end
      // Cycle ends once 384 samples seen and both channels gathered
      if (st_ff.samples == SAMPLE_CNT_W'(MIN_MEAS_SAMPLES) && st_ff.done_ch == 2'b11) begin
        sample_end = 1'b1;
      end
    end

    // Gather one channel per status block, channel 1 first then channel 2
    if (st_ff.enable && sub_stb && sub_chan == st_ff.gather_chan) begin
      if (sub_block_start) begin
        nxt_st.gathering = 1'b1;
        nxt_st.bit_idx = BIT_IDX_W'(1);
        nxt_st.shift = {{(CS_BITS-1){1'b0}}, sub_status};
      end else if (st_ff.gathering && !start) begin
        if (st_ff.bit_idx < BIT_IDX_W'(CS_BITS))
          nxt_st.shift[st_ff.bit_idx[5:0]] = sub_status;
        nxt_st.bit_idx = st_ff.bit_idx + 1'b1;
        if (st_ff.bit_idx == BIT_IDX_W'(BLOCK_FRAMES - 1)) begin
          nxt_st.gathering = 1'b0;
          if (st_ff.video_src) begin
            nxt_st.cs1 = st_ff.shift;
            nxt_st.cs2 = st_ff.shift;
            nxt_st.done_ch = 2'b11;
          end else begin
            if (st_ff.gather_chan) begin
              nxt_st.cs2 = st_ff.shift;
            end else begin
              nxt_st.cs1 = st_ff.shift;
            end
            nxt_st.done_ch[st_ff.gather_chan] = 1'b1;
            nxt_st.gather_chan = !st_ff.gather_chan;
          end
        end
      end
    end
    if (!st_ff.enable) begin
      nxt_st.gathering = 1'b0;
    end

    // Capture of reference status at the first completed cycle after a start
    if (sample_end) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
      if (!st_ff.ref_valid) begin
        nxt_st.ref1 = st_ff.cs1;
        nxt_st.ref2 = st_ff.cs2;
        nxt_st.ref_valid = 1'b1;
      end
      // Flags track the present condition only: sampled fresh each cycle
      nxt_st.flags[FLG_LOCK] = st_ff.acc_unlock;
      nxt_st.flags[FLG_PARITY] = st_ff.acc_parity || st_ff.acc_unlock;
      nxt_st.flags[FLG_CRC] = (pro1 && st_ff.acc_crc) || st_ff.acc_unlock;
      nxt_st.flags[FLG_NONPCM] = st_ff.cs1[BIT_AUDIO_MODE] || st_ff.acc_unlock;
      nxt_st.flags[FLG_CHANNEL1_VALIDITY_FLAG] = st_ff.acc_inv1 || st_ff.acc_unlock;
      nxt_st.flags[FLG_CHANNEL2_VALIDITY_FLAG] = st_ff.acc_inv2 || st_ff.acc_unlock;
      nxt_st.flags[FLG_PRO1] = pro1;
      nxt_st.flags[FLG_PRO2] = pro2;
      nxt_st.inv1 = st_ff.acc_inv1 || st_ff.acc_unlock;
      nxt_st.inv2 = st_ff.acc_inv2 || st_ff.acc_unlock;
    end

    // Marking with timed persistence
    if (!start) begin
      if ((diff1 & ~st_ff.mark1) != '0 || (diff2 & ~st_ff.mark2) != '0) nxt_st.age = '0;
      else if (st_ff.age != persist_lim) nxt_st.age = st_ff.age + 1'b1;
      nxt_st.mark1 = st_ff.mark1 | diff1;
      nxt_st.mark2 = st_ff.mark2 | diff2;
      if (st_ff.persist != PERSIST_FOREVER && st_ff.age == persist_lim && diff1 == '0 && diff2 == '0) begin
        nxt_st.mark1 = '0;
        nxt_st.mark2 = '0;
        nxt_st.age = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.flags <= RST_FLAGS;
      st_ff.inv1 <= 1'b1;
      st_ff.inv2 <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign channel1_validity_flag = st_ff.inv1;
  assign channel2_validity_flag = st_ff.inv2;
  assign meas_done = st_ff.done;
endmodule

// File: verif/csmon_props.sv
/*
  Port checker for csmon_monitor: APB handshake, refusals, flag sampling,
  lock override and minimum measurement length.
  Assumes one clock pclk and the asynchronous active-low reset presetn.
*/
module csmon_props
  import csmon_pkg::*;
#(
  parameter int SHORT_CYC = SHORT_PERSIST_CYC,
  parameter int LONG_CYC = LONG_PERSIST_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Front end and flags
  input wire logic lock_pin,
  input wire logic sub_stb,
  input wire logic sub_chan,
  input wire logic channel1_validity_flag,
  input wire logic channel2_validity_flag,
  input wire logic meas_done
);
  logic [15:0] ch1_cnt_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Channel 1 subframes seen since the last cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ch1_cnt_ff <= 16'h0000;
    else if (meas_done)
      ch1_cnt_ff <= 16'h0000;
    else if (sub_stb && !sub_chan && ch1_cnt_ff != 16'hFFFF)
      ch1_cnt_ff <= ch1_cnt_ff + 16'h0001;
  end

  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_wait: assert property (psel && penable && !pready && clk_en |=> pready) else $error("no pready");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_write_refused: assert property (psel && penable && pwrite && paddr != REG_CTRL && !pready && clk_en
    |=> pslverr) else $error("write not refused");
  a_done_pulse: assert property (meas_done |=> !meas_done) else $error("meas_done held");
  a_flags_sampled: assert property ($changed(channel1_validity_flag) || $changed(channel2_validity_flag)
    |-> meas_done) else $error("flag moved off cycle end");
  a_lock_forces: assert property ((!lock_pin) [*6] ##1 meas_done
    |-> channel1_validity_flag && channel2_validity_flag) else $error("lock loss not flagged");
  a_meas_min: assert property (meas_done |-> ch1_cnt_ff >= MIN_MEAS_SAMPLES) else $error("cycle short");

  c_done: cover property (meas_done);
  c_refused: cover property (pslverr);
  c_lock_lost: cover property (!lock_pin && meas_done);
endmodule

bind csmon_monitor csmon_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .lock_pin(lock_pin), .sub_stb(sub_stb),
  .sub_chan(sub_chan), .channel1_validity_flag(channel1_validity_flag),
  .channel2_validity_flag(channel2_validity_flag), .meas_done(meas_done));

// File: verif/csmon_src_model.sv
/*
  Transmitting device stand-in: one subframe every other pclk, ch1 then ch2,
  192-frame blocks carrying the given 40 status bits per channel.
  Assumes the bench sets content well before a measurement starts.
*/
module csmon_src_model
  import csmon_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stream content
  input wire logic locked,
  input wire logic [CS_BITS-1:0] cs1,
  input wire logic [CS_BITS-1:0] cs2,
  input wire logic val1,
  input wire logic val2,
  input wire logic par_bad,
  input wire logic crc_bad,
  // Front-end signals
  output logic lock_pin,
  output logic sub_stb,
  output logic sub_chan,
  output logic sub_block_start,
  output logic sub_status,
  output logic sub_validity,
  output logic sub_parity_err,
  output logic crc_err_stb
);
  logic [1:0] slot;
  logic [7:0] frame;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot <= 2'h0;
      frame <= 8'h00;
      lock_pin <= 1'b0;
      sub_stb <= 1'b0;
      sub_chan <= 1'b0;
      sub_block_start <= 1'b0;
      sub_status <= 1'b0;
      sub_validity <= 1'b0;
      sub_parity_err <= 1'b0;
      crc_err_stb <= 1'b0;
    end else begin
      slot <= slot + 2'h1;
      lock_pin <= locked;
      sub_stb <= slot[0];
      crc_err_stb <= crc_bad && slot == 2'h3 && frame == 8'hBF;
      if (slot[0]) begin
        sub_chan <= slot[1];
        sub_block_start <= frame == 8'h00;
        sub_status <= (frame < 8'd40) && (slot[1] ? cs2[frame[5:0]] : cs1[frame[5:0]]);
        sub_validity <= slot[1] ? val2 : val1;
        sub_parity_err <= par_bad;
      end else begin
        // Lines carry no subframe here: status, validity and parity toggle, block start clears
        sub_block_start <= 1'b0;
        sub_status <= ~sub_status;
        sub_validity <= ~sub_validity;
        sub_parity_err <= ~sub_parity_err;
      end
      if (slot == 2'h3)
        frame <= (frame == 8'hBF) ? 8'h00 : frame + 8'h01;
    end
  end
endmodule

// File: verif/csmon_monitor_tb_top.sv
/*
  Self-checking bench for csmon_monitor driven through APB and a source model.
  Assumes csmon_pkg, the design, the checker and the model are compiled first.
*/
module csmon_monitor_tb_top
  import csmon_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen, meas_done, vf1, vf2;
  logic locked, val1, val2, par_bad, crc_bad, lock_pin, sub_stb, sub_chan, sub_bs, sub_st, sub_va, sub_pe, crc_stb;
  logic [7:0] paddr;
  logic [1:0] pro;
  logic [31:0] pwdata, prdata, rd;
  logic [CS_BITS-1:0] cs1, cs2, gen, v, old;
  int errors, samples_checked, cyc;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

  always #20 pclk = ~pclk;

  csmon_monitor #(.SHORT_CYC(100), .LONG_CYC(500)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lock_pin(lock_pin), .sub_stb(sub_stb), .sub_chan(sub_chan),
    .sub_block_start(sub_bs), .sub_status(sub_st), .sub_validity(sub_va), .sub_parity_err(sub_pe),
    .crc_err_stb(crc_stb), .gen_status(gen), .channel1_validity_flag(vf1), .channel2_validity_flag(vf2),
    .meas_done(meas_done));
  csmon_src_model u_src (.pclk(pclk), .presetn(presetn), .locked(locked), .cs1(cs1), .cs2(cs2), .val1(val1),
    .val2(val2), .par_bad(par_bad), .crc_bad(crc_bad), .lock_pin(lock_pin), .sub_stb(sub_stb),
    .sub_chan(sub_chan), .sub_block_start(sub_bs), .sub_status(sub_st), .sub_validity(sub_va),
    .sub_parity_err(sub_pe), .crc_err_stb(crc_stb));

  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(negedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err_seen = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_cs(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    v[31:0] = rd;
    apb(1'b0, a + 8'h04, 32'h0);
    v[39:32] = rd[7:0];
  endtask

  // Start a single measurement and wait for its end
  task automatic meas(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, REG_CTRL, c);
    do begin @(negedge pclk); n++; end while (meas_done !== 1'b1 && n < 20000);
    `CHK("meas_done", 1'b1, meas_done)
    @(posedge pclk);
  endtask

  function automatic logic [31:0] ctl(input logic en, input logic vid, input logic [1:0] lay,
    input logic [1:0] mark);
    return {1'b1, 21'h0, 2'(PERSIST_FOREVER), mark, lay, 1'b0, vid, 1'b1, en};
  endfunction

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    locked = 1'b1;
    val1 = 1'b1;
    val2 = 1'b0;
    par_bad = 1'b0;
    crc_bad = 1'b1;
    cs1 = 40'hA5_1234_5670;
    cs2 = 40'h3C_0F0F_0F01;
    gen = 40'h5A_1234_5672;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_FLAGS, 32'h0);
    `CHK("flags_reset", 6'h3F, rd[5:0])
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped_err", 1'b1, err_seen)
    apb(1'b1, REG_FLAGS, 32'h0);
    `CHK("ro_write_err", 1'b1, err_seen)
    for (int i = 0; i < 3; i++) begin
      cs1[1] <= (i == 1);
      par_bad <= (i == 1);
      val1 <= i[0];
      val2 <= ~i[0];
      meas(ctl(1'b1, 1'b0, (i == 0) ? LAYOUT_CONSUMER : (i == 1) ? LAYOUT_PRO : LAYOUT_AUTO, i[1:0]));
      pro = (i == 1) ? 2'b11 : (i == 2) ? {cs2[0], cs1[0]} : 2'b00;
      `CHK("vflags", {val2, val1}, {vf2, vf1})
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("flags", {pro, val2, val1, cs1[1], i == 1, i == 1, 1'b0}, rd[7:0])
      rd_cs(REG_MARK1_LO);
      `CHK("mark1", (i == 0) ? 40'h0 : ((i == 1) ? cs1 ^ gen : cs1 ^ cs2) | 40'h00_0000_0002, v)
    end
    rd_cs(REG_MARK2_LO);
    `CHK("mark2", cs1 ^ cs2 | 40'h00_0000_0002, v)
    rd_cs(REG_CH1_LO);
    `CHK("cs1", cs1, v)
    rd_cs(REG_CH2_LO);
    `CHK("cs2", cs2, v)
    apb(1'b1, REG_CTRL, ctl(1'b1, 1'b0, LAYOUT_AUTO, MARK_CHANGES));
    rd_cs(REG_MARK1_LO);
    `CHK("mark_clear", 40'h0, v)
    old = cs1;
    cs1 <= cs1 ^ 40'h00_0000_0100;
    meas(ctl(1'b0, 1'b0, LAYOUT_AUTO, MARK_NONE));
    rd_cs(REG_CH1_LO);
    `CHK("cs_frozen", old, v)
    cs2 <= cs1;
    meas(ctl(1'b1, 1'b1, LAYOUT_AUTO, MARK_NONE));
    rd_cs(REG_CH2_LO);
    `CHK("video_ch2", cs1, v)
    locked <= 1'b0;
    meas(ctl(1'b1, 1'b0, LAYOUT_AUTO, MARK_NONE));
    apb(1'b0, REG_FLAGS, 32'h0);
    `CHK("lock_flags", 6'h3F, rd[5:0])
    complete_run();
  end
endmodule
